// ---- hw/adc_conversion_controller.sv ----
// conversion sequencer, prescaler, triggers and result registers of the adc controller
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module adc_conversion_controller (
  input  wire logic                                 ref_clk_i,     // peripheral clock
  input  wire logic                                 rst_i,         // sync reset, high
  input  wire logic                                 clk_run_i,     // peripheral clock gate
  input  wire logic [7:0]                           addr_i,        // register byte address
  input  wire logic [31:0]                          wdata_i,       // write data
  input  wire logic                                 wr_i,          // write strobe
  input  wire logic                                 rd_i,          // read strobe
  output logic      [31:0]                          rdata_o,       // read data, next cycle
  input  wire logic [adc_ctrl_pkg::NUM_TIMERS-1:0]  timer_output_a_i, // timer triggers
  input  wire logic                                 external_trigger_pin_i, // trigger pin
  input  wire logic                                 pen_detect_i,  // pen contact seen
  input  wire logic [adc_ctrl_pkg::DATA_W-1:0]      adc_data_i,    // converter output
  output logic      [adc_ctrl_pkg::CH_W-1:0]        channel_sel_o, // mux selection
  output logic                                      conv_start_o,  // converter start pulse
  output logic                                      conversion_clock_o, // converter clock
  output logic                                      dma_req_o,     // dma request pulse
  output logic                                      busy_o         // sequence running
);
  import adc_ctrl_pkg::*;

  // configuration
  logic [7:0]        clock_prescale_field;
  logic [3:0]        tracking_time_field;
  logic              low_resolution_select;
  logic [2:0]        hw_trigger_select;
  logic              tag_enable;
  trig_mode_t        trigger_source_mode;
  logic [15:0]       periodic_trigger_period;
  logic              pen_detect_enable;
  logic [NUM_CH-1:0] chan_enabled;
  // status
  logic [DATA_W-1:0] chan_result [NUM_CH];
  logic [DATA_W-1:0] last_result_value;
  logic [CH_W-1:0]   result_channel_number;
  logic [NUM_CH-1:0] chan_done;
  logic [NUM_CH-1:0] channel_overrun_flag;
  logic              result_ready_flag;
  logic              global_overrun_flag;
  // sequencer
  seq_state_t        state;
  logic [7:0]        pre_cnt;
  logic              tick;
  logic [4:0]        step_cnt;
  logic [4:0]        conv_cnt;
  logic              conv_busy;
  logic [CH_W-1:0]   conv_chan;
  logic [15:0]       per_cnt;
  logic              trig_sync1;
  logic              trig_sync2;
  logic              trig_prev;
  logic              sw_start;
  logic              seq_end;

  wire logic wr_hit_cmd = wr_i && addr_i == OFS_COMMAND;
  wire logic rd_last    = rd_i && addr_i == OFS_LAST;
  wire logic rd_event   = rd_i && addr_i == OFS_EVENT;
  wire logic rd_ovr     = rd_i && addr_i == OFS_OVERRUN;
  wire logic rd_result  = rd_i && addr_i >= OFS_RESULT0 && addr_i <= OFS_RESULT_LAST
                          && addr_i[1:0] == 2'h0;
  wire logic [7:0] res_ofs = addr_i - OFS_RESULT0;
  wire logic [CH_W-1:0] rd_chan = res_ofs[CH_W+1:2];

  // lowest enabled channel at or above from; valid flag in the top bit
  function automatic logic [CH_W:0] next_enabled(input logic [NUM_CH-1:0] mask,
                                                 input logic [CH_W:0]     from);
    logic [CH_W:0] found;
    found = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (mask[i] && i >= int'(from)) begin
        found = {1'b1, CH_W'(i)};
      end
    end
    return found;
  endfunction

  // ---------------- configuration writes (never gated) ----------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      clock_prescale_field    <= RESET_ZERO[7:0];
      tracking_time_field     <= RESET_ZERO[3:0];
      low_resolution_select   <= 1'b0;
      hw_trigger_select       <= RESET_ZERO[2:0];
      tag_enable              <= 1'b0;
      trigger_source_mode     <= TRG_OFF;
      periodic_trigger_period <= RESET_ZERO[15:0];
      pen_detect_enable       <= 1'b0;
    end else if (wr_i) begin
      unique case (addr_i)
        OFS_MODE: begin
          clock_prescale_field  <= wdata_i[MODE_PRE_LO +: 8];
          tracking_time_field   <= wdata_i[MODE_TRK_LO +: 4];
          low_resolution_select <= wdata_i[MODE_LOW_RESOLUTION_SELECT];
          hw_trigger_select     <= wdata_i[MODE_TSEL_LO +: 3];
        end
        OFS_EXTMODE: tag_enable <= wdata_i[EMR_TAG_BIT];
        OFS_TRIGGER: begin
          trigger_source_mode     <= trig_mode_t'(wdata_i[TRG_MODE_LO +: 3]);
          periodic_trigger_period <= wdata_i[TRG_PER_LO +: 16];
        end
        OFS_TOUCH: pen_detect_enable <= wdata_i[TSMR_PEN_BIT];
        default: ;
      endcase
    end
  end

  // set and clear registers act only on the bits written as one
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      chan_enabled <= RESET_ZERO[NUM_CH-1:0];
    end else if (wr_i && addr_i == OFS_CH_ENABLE) begin
      chan_enabled <= chan_enabled | wdata_i[NUM_CH-1:0];
    end else if (wr_i && addr_i == OFS_CH_DISABL) begin
      chan_enabled <= chan_enabled & ~wdata_i[NUM_CH-1:0];
    end
  end

  // ---------------- conversion clock ----------------
  // one tick per conversion clock period: 2*(prescale+1) peripheral cycles
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pre_cnt            <= RESET_ZERO[7:0];
      conversion_clock_o <= 1'b0;
      tick               <= 1'b0;
    end else if (clk_run_i) begin
      tick <= 1'b0;
      if (pre_cnt >= clock_prescale_field) begin
        pre_cnt            <= RESET_ZERO[7:0];
        conversion_clock_o <= ~conversion_clock_o;
        tick               <= ~conversion_clock_o;
      end else begin
        pre_cnt <= pre_cnt + 8'h01;
      end
    end else begin
      tick <= 1'b0;
    end
  end

  // ---------------- triggers ----------------
  wire logic sel_src = (hw_trigger_select == TSEL_EXT_PIN) ? external_trigger_pin_i
                     : (int'(hw_trigger_select) < NUM_TIMERS)
                       ? timer_output_a_i[hw_trigger_select] : 1'b0;

  // the trigger source may be fed from another clock, so it is resynchronised
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      trig_sync1 <= 1'b0;
      trig_sync2 <= 1'b0;
      trig_prev  <= 1'b0;
    end else begin
      trig_sync1 <= sel_src;
      trig_sync2 <= trig_sync1;
      trig_prev  <= trig_sync2;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      per_cnt <= RESET_ZERO[15:0];
    end else if (trigger_source_mode != TRG_PERIODIC) begin
      per_cnt <= RESET_ZERO[15:0];
    end else if (tick) begin
      per_cnt <= (per_cnt >= periodic_trigger_period) ? RESET_ZERO[15:0] : per_cnt + 16'h0001;
    end
  end

  // software start is held until the gated clock lets the sequencer see it
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sw_start <= 1'b0;
    end else if (wr_hit_cmd && wdata_i[CMD_START_BIT]) begin
      sw_start <= 1'b1;
    end else if (clk_run_i) begin
      sw_start <= 1'b0;
    end
  end

  logic hw_trig;
  always_comb begin
    hw_trig = 1'b0;
    unique case (trigger_source_mode)
      TRG_OFF:        hw_trig = 1'b0;
      TRG_RISE:       hw_trig = trig_sync2 && !trig_prev;
      TRG_FALL:       hw_trig = !trig_sync2 && trig_prev;
      TRG_ANY:        hw_trig = trig_sync2 != trig_prev;
      TRG_PEN:        hw_trig = pen_detect_enable && pen_detect_i;
      TRG_CONTINUOUS: hw_trig = 1'b1;
      TRG_PERIODIC:   hw_trig = tick && per_cnt >= periodic_trigger_period;
      default:        hw_trig = 1'b0;
    endcase
  end

  wire logic [CH_W:0] first_ch = next_enabled(chan_enabled, '0);
  wire logic [CH_W:0] next_ch  = next_enabled(chan_enabled, (CH_W+1)'(channel_sel_o) + 5'h01);

  // ---------------- sequencer ----------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state         <= SEQ_IDLE;
      step_cnt      <= RESET_ZERO[4:0];
      channel_sel_o <= RESET_ZERO[CH_W-1:0];
      conv_start_o  <= 1'b0;
      busy_o        <= 1'b0;
    end else if (clk_run_i) begin
      conv_start_o <= 1'b0;
      unique case (state)
        SEQ_IDLE: begin
          busy_o <= 1'b0;
          // only idle listens, so triggers during a sequence are dropped
          if ((sw_start || hw_trig) && first_ch[CH_W]) begin
            channel_sel_o <= first_ch[CH_W-1:0];
            step_cnt      <= RESET_ZERO[4:0];
            busy_o        <= 1'b1;
            state         <= SEQ_TRACK;
          end
        end
        SEQ_TRACK: begin
          if (tick) begin
            if (step_cnt >= {1'b0, tracking_time_field} && !conv_busy) begin
              conv_start_o <= 1'b1;
              step_cnt     <= RESET_ZERO[4:0];
              state        <= SEQ_HOLD;
            end else if (step_cnt < {1'b0, tracking_time_field}) begin
              step_cnt <= step_cnt + 5'h01;
            end
          end
        end
        SEQ_HOLD: begin
          if (tick) begin
            if (step_cnt + 5'h01 >= HOLD_CYCLES) begin
              step_cnt <= RESET_ZERO[4:0];
              if (next_ch[CH_W]) begin
                channel_sel_o <= next_ch[CH_W-1:0];
                state         <= SEQ_TRACK;
              end else begin
                state <= SEQ_DRAIN;
              end
            end else begin
              step_cnt <= step_cnt + 5'h01;
            end
          end
        end
        SEQ_DRAIN: begin
          if (!conv_busy && !conv_start_o) begin
            state <= SEQ_IDLE;
          end
        end
      endcase
    end else begin
      conv_start_o <= 1'b0;
    end
  end

  // converter time: result is taken after a fixed count of conversion clocks
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      conv_busy <= 1'b0;
      conv_cnt  <= RESET_ZERO[4:0];
      conv_chan <= RESET_ZERO[CH_W-1:0];
      seq_end   <= 1'b0;
    end else begin
      seq_end <= 1'b0;
      if (conv_start_o) begin
        conv_busy <= 1'b1;
        conv_cnt  <= RESET_ZERO[4:0];
        conv_chan <= channel_sel_o;
      end else if (conv_busy && tick) begin
        if (conv_cnt + 5'h01 >= CONV_CYCLES) begin
          conv_busy <= 1'b0;
          seq_end   <= 1'b1;
        end else begin
          conv_cnt <= conv_cnt + 5'h01;
        end
      end
    end
  end

  wire logic done = seq_end;
  wire logic [DATA_W-1:0] res_val = low_resolution_select
                                    ? {2'b00, adc_data_i[DATA_W-1:2]} : adc_data_i;

  // ---------------- results and flags ----------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        chan_result[i] <= RESET_ZERO[DATA_W-1:0];
      end
      last_result_value     <= RESET_ZERO[DATA_W-1:0];
      result_channel_number <= RESET_ZERO[CH_W-1:0];
    end else if (done) begin
      chan_result[conv_chan] <= res_val;
      last_result_value      <= res_val;
      result_channel_number  <= tag_enable ? conv_chan : RESET_ZERO[CH_W-1:0];
    end
  end

  // on every flag the set from a completion wins over a clearing read
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      chan_done            <= RESET_ZERO[NUM_CH-1:0];
      channel_overrun_flag <= RESET_ZERO[NUM_CH-1:0];
      result_ready_flag    <= 1'b0;
      global_overrun_flag  <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (done && conv_chan == CH_W'(i)) begin
          chan_done[i] <= 1'b1;
          if (chan_done[i]) begin
            channel_overrun_flag[i] <= 1'b1;
          end else if (rd_ovr) begin
            channel_overrun_flag[i] <= 1'b0;
          end
        end else begin
          if (rd_result && rd_chan == CH_W'(i)) begin
            chan_done[i] <= 1'b0;
          end
          if (rd_ovr) begin
            channel_overrun_flag[i] <= 1'b0;
          end
        end
      end
      if (done) begin
        result_ready_flag <= 1'b1;
      end else if (rd_last) begin
        result_ready_flag <= 1'b0;
      end
      if (done && result_ready_flag) begin
        global_overrun_flag <= 1'b1;
      end else if (rd_event) begin
        global_overrun_flag <= 1'b0;
      end
    end
  end

  // a request per result that raises the ready flag; a channel disabled meanwhile gets none
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      dma_req_o <= 1'b0;
    end else begin
      dma_req_o <= done && !result_ready_flag && chan_enabled[conv_chan];
    end
  end

  // ---------------- read port ----------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= RESET_ZERO;
    end else if (rd_i) begin
      rdata_o <= RESET_ZERO;
      if (rd_result) begin
        rdata_o[DATA_W-1:0] <= chan_result[rd_chan];
      end else begin
        unique case (addr_i)
          OFS_MODE: begin
            rdata_o[MODE_PRE_LO +: 8]  <= clock_prescale_field;
            rdata_o[MODE_TRK_LO +: 4]  <= tracking_time_field;
            rdata_o[MODE_LOW_RESOLUTION_SELECT]       <= low_resolution_select;
            rdata_o[MODE_TSEL_LO +: 3] <= hw_trigger_select;
          end
          OFS_EXTMODE: rdata_o[EMR_TAG_BIT] <= tag_enable;
          OFS_TRIGGER: begin
            rdata_o[TRG_MODE_LO +: 3] <= trigger_source_mode;
            rdata_o[TRG_PER_LO +: 16] <= periodic_trigger_period;
          end
          OFS_CH_STATUS: rdata_o[NUM_CH-1:0] <= chan_enabled;
          OFS_LAST: begin
            rdata_o[DATA_W-1:0]          <= last_result_value;
            rdata_o[LAST_RESULT_CHANNEL_NUMBER_LO +: CH_W] <= result_channel_number;
          end
          OFS_EVENT: begin
            rdata_o[NUM_CH-1:0]   <= chan_done;
            rdata_o[EVT_RESULT_READY_FLAG_BIT] <= result_ready_flag;
            rdata_o[EVT_GLOBAL_OVERRUN_FLAG_BIT] <= global_overrun_flag;
          end
          OFS_OVERRUN: rdata_o[NUM_CH-1:0] <= channel_overrun_flag;
          OFS_TOUCH:   rdata_o[TSMR_PEN_BIT] <= pen_detect_enable;
          default: ;
        endcase
      end
    end
  end
endmodule

// ---- hw/adc_ctrl_pkg.sv ----
// constants, register map and field layout of the conversion controller
// Behaviour
// - programmable tracking time after channel change
// - hold channel fixed cycles after each start
// - prescale 0 gives half, 255 gives 1/512
// - full 10-bit results after reset
// - low resolution gives 8 bits, top zero
// - result to channel and last registers
// - optional channel number in last result
// - completion sets done, ready; ready rise requests DMA
// - channel result reads clear done, last result reads clear ready
// - unread channel result overwritten sets channel overrun
// - completion while ready set sets global overrun
// - status reads clear overrun flags
// - command start bit issues software trigger
// - hardware source: timer output or pin
// - trigger modes: edges, pen, continuous, periodic
// - hardware edges synchronised before starting
// - one trigger converts all enabled channels
// - enable and disable registers act per channel
// - DMA requests only for enabled channels
// - register writes accepted with clock gated
package adc_ctrl_pkg;
  localparam int          NUM_CH        = 12;
  localparam int          CH_W          = 4;
  localparam int          DATA_W        = 10;
  localparam int          NUM_TIMERS    = 6;
  // register byte addresses
  localparam logic [7:0]  OFS_COMMAND   = 8'h00;
  localparam logic [7:0]  OFS_MODE      = 8'h04;
  localparam logic [7:0]  OFS_EXTMODE   = 8'h08;
  localparam logic [7:0]  OFS_TRIGGER   = 8'h0c;
  localparam logic [7:0]  OFS_CH_ENABLE = 8'h10;
  localparam logic [7:0]  OFS_CH_DISABL = 8'h14;
  localparam logic [7:0]  OFS_CH_STATUS = 8'h18;
  localparam logic [7:0]  OFS_LAST      = 8'h1c;
  localparam logic [7:0]  OFS_EVENT     = 8'h20;
  localparam logic [7:0]  OFS_OVERRUN   = 8'h24;
  localparam logic [7:0]  OFS_TOUCH     = 8'h28;
  localparam logic [7:0]  OFS_RESULT0   = 8'h30;
  localparam logic [7:0]  OFS_RESULT_LAST = 8'h5c;
  // field positions
  localparam int          CMD_START_BIT = 0;
  localparam int          MODE_LOW_RESOLUTION_SELECT   = 4;
  localparam int          MODE_TSEL_LO  = 0;
  localparam int          MODE_PRE_LO   = 8;
  localparam int          MODE_TRK_LO   = 24;
  localparam int          EMR_TAG_BIT   = 24;
  localparam int          TRG_MODE_LO   = 0;
  localparam int          TRG_PER_LO    = 16;
  localparam int          EVT_RESULT_READY_FLAG_BIT  = 24;
  localparam int          EVT_GLOBAL_OVERRUN_FLAG_BIT = 25;
  localparam int          LAST_RESULT_CHANNEL_NUMBER_LO  = 12;
  localparam int          TSMR_PEN_BIT  = 0;
  localparam logic [2:0]  TSEL_EXT_PIN  = 3'h6;
  // timing in conversion clock cycles
  localparam logic [4:0]  HOLD_CYCLES   = 5'h03;
  localparam logic [4:0]  CONV_CYCLES   = 5'h0a;
  localparam logic [31:0] RESET_ZERO    = 32'h0000_0000;

  typedef enum logic [2:0] {
    TRG_OFF        = 3'b000,
    TRG_RISE       = 3'b001,
    TRG_FALL       = 3'b010,
    TRG_ANY        = 3'b011,
    TRG_PEN        = 3'b100,
    TRG_CONTINUOUS = 3'b101,
    TRG_PERIODIC   = 3'b110
  } trig_mode_t;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_TRACK = 2'b01,
    SEQ_HOLD  = 2'b10,
    SEQ_DRAIN = 2'b11
  } seq_state_t;
endpackage

// ---- tb/adc_conversion_controller_monitor.sv ----
// port assertions for the adc conversion controller
`timescale 1ns/1ps
module adc_ctrl_monitor
  import adc_ctrl_pkg::*;
(
  input logic            ref_clk_i,          // clock
  input logic            rst_i,              // reset
  input logic            clk_run_i,          // clock gate
  input logic [7:0]      addr_i,             // address
  input logic [31:0]     wdata_i,            // write data
  input logic            wr_i,               // write strobe
  input logic [CH_W-1:0] channel_sel_o,      // mux channel
  input logic            conv_start_o,       // start pulse
  input logic            conversion_clock_o, // divided clock
  input logic            dma_req_o,          // dma pulse
  input logic            busy_o              // sequence running
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] pre;
  logic [8:0] run_cnt;
  logic       last_clk;
  logic       settled;
  wire        toggled = conversion_clock_o != last_clk;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) pre <= 8'h00;
    else if (wr_i && addr_i == OFS_MODE) pre <= wdata_i[MODE_PRE_LO +: 8];
  end
  // half periods are counted only over running cycles
  always_ff @(posedge ref_clk_i) begin
    last_clk <= conversion_clock_o;
    if (toggled) run_cnt <= 9'h000;
    else if (clk_run_i) run_cnt <= run_cnt + 9'h001;
  end
  // a gate pause or a new prescale spoils the half period in flight
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !clk_run_i || (wr_i && addr_i == OFS_MODE)) settled <= 1'b0;
    else if (toggled) settled <= 1'b1;
  end
  sequence start_s;
    conv_start_o;
  endsequence
  sequence sel_move_s;
    $changed(channel_sel_o);
  endsequence
  hold_stable_a: assert property (start_s |=> $stable(channel_sel_o)[*5])
    else $error("channel changed during hold");
  track_gap_a: assert property (sel_move_s |-> !conv_start_o[*2])
    else $error("start too soon after channel change");
  start_delay_a: assert property ($rose(busy_o) |-> ##[2:600] start_s)
    else $error("no start after sequence began");
  start_busy_a: assert property (start_s |-> busy_o)
    else $error("start outside a sequence");
  clk_div_a: assert property (toggled && settled |-> run_cnt == {1'b0, pre})
    else $error("conversion clock half period wrong");
  dma_pulse_a: assert property (dma_req_o |=> !dma_req_o)
    else $error("dma request longer than one cycle");
  reset_idle_a: assert property (disable iff (1'b0) rst_i |=> !busy_o && !dma_req_o)
    else $error("outputs active after reset");
  gate_freeze_a: assert property (!clk_run_i && !$past(clk_run_i) |-> !conv_start_o)
    else $error("start while clock gated");
endmodule

bind adc_conversion_controller adc_ctrl_monitor u_mon (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_run_i(clk_run_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .channel_sel_o(channel_sel_o),
  .conv_start_o(conv_start_o), .conversion_clock_o(conversion_clock_o),
  .dma_req_o(dma_req_o), .busy_o(busy_o));

// ---- tb/adc_source_model.sv ----
// analog source and converter model: a per-channel code after each start
`timescale 1ns/1ps
module adc_source_model
  import adc_ctrl_pkg::*;
(
  input  logic              ref_clk_i,     // clock
  input  logic [CH_W-1:0]   channel_sel_i, // selected channel
  input  logic              conv_start_i,  // start pulse
  output logic [DATA_W-1:0] adc_data_o     // converted code
);
  // the code carries the channel so a misrouted result shows up
  initial adc_data_o = 10'h155;
  always @(posedge ref_clk_i) begin
    if (conv_start_i) adc_data_o <= {channel_sel_i, 6'h2d};
  end
endmodule

// ---- tb/adc_conversion_controller_bench.sv ----
// self-checking bench for the adc conversion controller
`timescale 1ns/1ps
module adc_conversion_controller_bench;
  import adc_ctrl_pkg::*;
  logic                  ref_clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic                  clk_run_i = 1'b1;
  logic [7:0]            addr_i = 8'h00;
  logic [31:0]           wdata_i = 32'h0;
  logic                  wr_i = 1'b0;
  logic                  rd_i = 1'b0;
  logic [NUM_TIMERS-1:0] timer_output_a_i = '0;
  logic                  external_trigger_pin_i = 1'b0;
  logic                  pen_detect_i = 1'b0;
  logic [DATA_W-1:0]     adc_data_i;
  logic [31:0]           rdata_o;
  logic [CH_W-1:0]       channel_sel_o;
  logic                  conv_start_o, conversion_clock_o, dma_req_o, busy_o;
  int                    n_mismatch = 0, n_tests = 0, n_dma = 0, k;
  logic [CH_W-1:0]       order [$];
  logic [2:0]            tmode [7] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h0};
  logic [6:0]            texp = 7'b0111001;
  always #2 ref_clk_i = ~ref_clk_i;
  adc_conversion_controller u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .clk_run_i(clk_run_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .timer_output_a_i(timer_output_a_i),
    .external_trigger_pin_i(external_trigger_pin_i), .pen_detect_i(pen_detect_i),
    .adc_data_i(adc_data_i), .channel_sel_o(channel_sel_o), .conv_start_o(conv_start_o),
    .conversion_clock_o(conversion_clock_o), .dma_req_o(dma_req_o), .busy_o(busy_o));
  adc_source_model u_src (.ref_clk_i(ref_clk_i), .channel_sel_i(channel_sel_o),
    .conv_start_i(conv_start_o), .adc_data_o(adc_data_i));
  always @(posedge ref_clk_i) begin
    if (conv_start_o) order.push_back(channel_sel_o);
    if (dma_req_o) n_dma++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, exp);
  endtask
  // waits for a sequence to begin (or not) and then to finish
  task automatic seq(input logic exp);
    int i;
    logic seen;
    seen = 1'b0;
    for (i = 0; i < 300 && !seen; i++) begin
      @(posedge ref_clk_i);
      #1 seen = busy_o;
    end
    check(seen, exp);
    for (i = 0; i < 3000 && busy_o; i++) @(posedge ref_clk_i);
    repeat (4) @(posedge ref_clk_i);
    // a sequence that never ends must not slip through as a pass
    #1 check(busy_o, 1'b0);
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    results;
  end
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(OFS_MODE, 32'h0);
    rd(OFS_EVENT, 32'h0);
    wr(OFS_MODE, 32'h0200_0100);
    wr(OFS_EXTMODE, 32'h0100_0000);
    wr(OFS_CH_ENABLE, 32'h0000_000a);
    rd(OFS_CH_STATUS, 32'h0000_000a);
    wr(OFS_COMMAND, 32'h1);
    seq(1'b1);
    check({order[0], order[1]}, 8'h13);
    // nobody reads the last result in between, so channel 3 raises no request
    check(n_dma, 1);
    rd(OFS_EVENT, 32'h0300_000a);
    rd(OFS_RESULT0 + 8'h04, 32'h06d);
    rd(OFS_LAST, 32'h0000_30ed);
    rd(OFS_EVENT, 32'h0000_0008);
    order.delete();
    n_dma = 0;
    wr(OFS_COMMAND, 32'h1);
    repeat (20) @(posedge ref_clk_i);
    wr(OFS_COMMAND, 32'h1);
    seq(1'b1);
    check(order.size(), 2);
    check(busy_o, 1'b0);
    check(n_dma, 1);
    rd(OFS_OVERRUN, 32'h0000_0008);
    rd(OFS_OVERRUN, 32'h0);
    rd(OFS_EVENT, 32'h0300_000a);
    rd(OFS_EVENT, 32'h0100_000a);
    // channels are only disabled while the sequencer idles
    wr(OFS_CH_DISABL, 32'h8);
    rd(OFS_CH_STATUS, 32'h2);
    wr(OFS_MODE, 32'h0200_0110);
    order.delete();
    wr(OFS_COMMAND, 32'h1);
    seq(1'b1);
    check(order.size(), 1);
    rd(OFS_RESULT0 + 8'h04, 32'h01b);
    rd(OFS_LAST, 32'h0000_101b);
    wr(OFS_MODE, 32'h0200_0106);
    // each step waits out the sequence, so triggers stay spaced apart
    for (k = 0; k < 7; k++) begin
      wr(OFS_TRIGGER, {29'h0, tmode[k]});
      @(posedge ref_clk_i) external_trigger_pin_i <= ~external_trigger_pin_i;
      @(posedge ref_clk_i);
      #1 check(busy_o, 1'b0);
      seq(texp[k]);
    end
    wr(OFS_MODE, 32'h0200_0100);
    wr(OFS_TRIGGER, 32'h1);
    @(posedge ref_clk_i) timer_output_a_i[0] <= 1'b1;
    seq(1'b1);
    wr(OFS_TOUCH, 32'h1);
    wr(OFS_TRIGGER, 32'h4);
    @(posedge ref_clk_i) pen_detect_i <= 1'b1;
    // a short contact: a held level would retrigger without pause
    @(posedge ref_clk_i) pen_detect_i <= 1'b0;
    seq(1'b1);
    order.delete();
    wr(OFS_TRIGGER, 32'h5);
    repeat (400) @(posedge ref_clk_i);
    wr(OFS_TRIGGER, 32'h0);
    seq(1'b1);
    check(order.size() > 2, 1'b1);
    order.delete();
    wr(OFS_TRIGGER, {16'd40, 16'h0006});
    repeat (600) @(posedge ref_clk_i);
    // catch the next periodic sequence before the trigger is switched off
    seq(1'b1);
    wr(OFS_TRIGGER, 32'h0);
    check(order.size() inside {[3:5]}, 1'b1);
    wr(OFS_EXTMODE, 32'h0);
    @(posedge ref_clk_i) clk_run_i <= 1'b0;
    wr(OFS_MODE, 32'h0200_0110);
    rd(OFS_MODE, 32'h0200_0110);
    wr(OFS_COMMAND, 32'h1);
    repeat (20) @(posedge ref_clk_i);
    #1 check(busy_o, 1'b0);
    @(posedge ref_clk_i) clk_run_i <= 1'b1;
    seq(1'b1);
    rd(OFS_LAST, 32'h0000_001b);
    results;
  end
endmodule
